/* logic/fpl_pkg.sv */
// package of constants and encodings for the front panel lamp logic
// assumes settings arrive as the plain codes defined here
package fpl_pkg;
  // ****************************************************
  // rectifier and display codes
  // ****************************************************
  localparam logic [2:0] RECT_ACDC     = 3'h0;
  localparam logic [2:0] RECT_ACDC_UMN = 3'h1;
  localparam logic [2:0] RECT_DC       = 3'h2;
  localparam logic [2:0] RECT_AC       = 3'h3;
  localparam logic [2:0] RECT_FUND     = 3'h4;
  localparam int         DISP_W        = 5;
  localparam logic [4:0] DISP_UK       = 5'h09;
  localparam logic [4:0] DISP_IK       = 5'h0A;
  localparam logic [4:0] DISP_PK       = 5'h0B;
  localparam logic [4:0] DISP_UHDK     = 5'h0C;
  localparam logic [4:0] DISP_IHDK     = 5'h0D;
  localparam logic [4:0] DISP_PHDK     = 5'h0E;
  // ****************************************************
  // setting codes and defaults
  // ****************************************************
  localparam logic [1:0] SYNC_SRC_U    = 2'h0;
  localparam logic [1:0] TOUT_100MS    = 2'h0;
  localparam logic [1:0] FILT_500HZ    = 2'h1;
  localparam logic [1:0] CURIN_DIRECT  = 2'h0;
  localparam logic [1:0] LINK_OFF      = 2'h0;
  localparam logic [1:0] LINK_MASTER   = 2'h1;
  localparam logic [1:0] LINK_SLAVE    = 2'h2;
  localparam logic [1:0] INTEG_RESET   = 2'h0;
  localparam logic [1:0] INTEG_RUN     = 2'h1;
  localparam logic [1:0] INTEG_STOP    = 2'h2;
  localparam logic [7:0] AVG_DEFAULT   = 8'h01;
  localparam logic [15:0] RATIO_ONE    = 16'h0001;
  localparam logic [7:0] ZC_DEFAULT    = 8'h01;
  localparam logic [5:0] ORDER_DEFAULT = 6'h32;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int BLINK_MS     = 250;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  localparam int PULSE_MS     = 100;
  localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
  // hold sequence states
  typedef enum logic [1:0] {FPL_LIVE, FPL_HOLD, FPL_MAX, FPL_MIN} fpl_hold_t;
endpackage : fpl_pkg

/* logic/fpl_blink_if.sv */
// interface carrying the shared blink phase from the divider to the lamp logic
// assumes one clock domain
`timescale 1ns/1ns
interface fpl_blink_if;
  logic phase;
  logic tick;
  modport src (output phase, output tick);
  modport dst (input phase, input tick);
endinterface : fpl_blink_if

/* logic/fpl_blink.sv */
// blink divider: one enable pulse per half period and a square phase
// assumes synchronous active low reset
`timescale 1ns/1ns
module fpl_blink
  import fpl_pkg::*;
#(
  parameter int HALF_CYCLES = BLINK_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  fpl_blink_if.src   bl
);
  logic [31:0] cnt_r;
  logic        phase_r;
  logic        tick_r;
  // divider counts up to the enable pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b0;
    end else if (cnt_r == 32'(HALF_CYCLES - 1)) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end
  // phase toggles on each pulse; the flashing run lamp follows it, while the link flash is only ended by the pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= 1'b0;
    end else if (tick_r) begin
      phase_r <= ~phase_r;
    end
  end
  assign bl.phase = phase_r;
  assign bl.tick  = tick_r;
endmodule : fpl_blink

/* logic/fpl_lamps.sv */
// front panel status lamp logic of a single phase power meter
// assumes key strobes are one-cycle pulses synchronous to CLK
`timescale 1ns/1ns
module fpl_lamps
  import fpl_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_CYCLES,
  parameter int PULSE_LEN  = PULSE_CYCLES
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic [2:0]       RECT_SEL,
  input  wire logic [DISP_W-1:0] DISP_SEL,
  input  wire logic             INTEG_AUTO_MODE,
  input  wire logic [1:0]       INTEG_STATE,
  input  wire logic             INTEG_EXTERNAL,
  input  wire logic             KEY_SHIFT,
  input  wire logic             KEY_HOLD,
  input  wire logic             KEY_MAXMIN,
  input  wire logic [1:0]       SYNC_SRC,
  input  wire logic [1:0]       SYNC_TIMEOUT,
  input  wire logic [1:0]       FILTER_SEL,
  input  wire logic [7:0]       AVG_COUNT,
  input  wire logic [15:0]      VOLTAGE_TRANSFORMER_RATIO,
  input  wire logic [15:0]      CURRENT_TRANSFORMER_RATIO,
  input  wire logic [1:0]       CURRENT_INPUT,
  input  wire logic             RANGE_SEL_OFF_U,
  input  wire logic             RANGE_SEL_OFF_I,
  input  wire logic [7:0]       ZC_LEVEL_U,
  input  wire logic [7:0]       ZC_LEVEL_I,
  input  wire logic [5:0]       ORDER_LIMIT,
  input  wire logic [1:0]       LINK_MODE,
  input  wire logic             LINK_SYNC_IN,
  input  wire logic             RANGE_AUTO_U,
  input  wire logic             RANGE_AUTO_I,
  output logic                  LAMP_DC,
  output logic                  LAMP_AC,
  output logic                  LAMP_UMN,
  output logic                  LAMP_FUNDAMENTAL_RECTIFIER,
  output logic                  LAMP_LEVEL,
  output logic                  CONTENT_PERCENT_LAMP,
  output logic                  LAMP_INTEG_AUTO,
  output logic                  LAMP_RUN,
  output logic                  OUTSIDE_CONTROL_LAMP,
  output logic                  LAMP_HOLD,
  output logic                  LAMP_MAX,
  output logic                  LAMP_MIN,
  output logic                  HOLD_DISPLAY,
  output logic                  LAMP_TIMING_SOURCE,
  output logic                  LAMP_DETECT_LIMIT,
  output logic                  FILTER_SETTING_LAMP,
  output logic                  AVERAGING_SETTING_LAMP,
  output logic                  LAMP_VOLTAGE_TRANSFORMER_RATIO,
  output logic                  LAMP_CURRENT_TRANSFORMER_RATIO,
  output logic                  LAMP_SENSOR,
  output logic                  LAMP_RANGE_SKIP,
  output logic                  ORDER_CAP_LAMP,
  output logic                  LAMP_LINK,
  output logic                  LAMP_RANGE_AUTO
);
  // ****************************************************
  // shared blink
  // ****************************************************
  fpl_blink_if bl ();
  fpl_blink #(
    .HALF_CYCLES (BLINK_HALF)
  ) u_blink (
    .clk   (CLK),
    .rst_n (RST_N),
    .bl    (bl)
  );

  // harmonic level display decode, used by lamp and check
  function automatic logic is_level(input logic [DISP_W-1:0] d);
    return (d == DISP_UK) || (d == DISP_IK) || (d == DISP_PK);
  endfunction : is_level

  function automatic logic is_percent(input logic [DISP_W-1:0] d);
    return (d == DISP_UHDK) || (d == DISP_IHDK) || (d == DISP_PHDK);
  endfunction : is_percent

  // ****************************************************
  // hold sequence
  // ****************************************************
  fpl_hold_t hold_r;
  fpl_hold_t hold_nxt;
  logic      shift_r;

  // shift arms the next hold press; any other key disarms it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      shift_r <= 1'b0;
    end else if (KEY_SHIFT) begin
      shift_r <= 1'b1;
    end else if (KEY_HOLD || KEY_MAXMIN) begin
      shift_r <= 1'b0;
    end
  end

  // next hold state from key presses
  always_comb begin
    hold_nxt = hold_r;
    case (hold_r)
      FPL_LIVE: begin
        if (KEY_HOLD && shift_r) begin
          hold_nxt = FPL_HOLD;
        end else if (KEY_MAXMIN) begin
          hold_nxt = FPL_MAX;
        end
      end
      FPL_HOLD: if (KEY_HOLD) hold_nxt = FPL_LIVE;
      FPL_MAX:  if (KEY_HOLD) hold_nxt = FPL_MIN;
      FPL_MIN:  if (KEY_HOLD) hold_nxt = FPL_LIVE;
      default:  hold_nxt = FPL_LIVE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hold_r <= FPL_LIVE;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // ****************************************************
  // slave sync flash stretch
  // ****************************************************
  // a short sync edge would be invisible, so it is stretched until the next blink tick
  logic sync_d_r;
  logic link_flash_r;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync_d_r <= 1'b0;
    end else begin
      sync_d_r <= LINK_SYNC_IN;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      link_flash_r <= 1'b0;
    end else if (LINK_SYNC_IN && !sync_d_r) begin
      link_flash_r <= 1'b1;
    end else if (bl.tick) begin
      link_flash_r <= 1'b0;
    end
  end

  // ****************************************************
  // lamp registers
  // ****************************************************
  // rectifier and harmonic lamps
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LAMP_DC                    <= 1'b0;
      LAMP_AC                    <= 1'b0;
      LAMP_UMN                   <= 1'b0;
      LAMP_FUNDAMENTAL_RECTIFIER <= 1'b0;
      LAMP_LEVEL                 <= 1'b0;
      CONTENT_PERCENT_LAMP       <= 1'b0;
    end else begin
      LAMP_DC  <= (RECT_SEL == RECT_ACDC) || (RECT_SEL == RECT_ACDC_UMN)
                  || (RECT_SEL == RECT_DC);
      LAMP_AC  <= (RECT_SEL == RECT_ACDC) || (RECT_SEL == RECT_ACDC_UMN)
                  || (RECT_SEL == RECT_AC);
      LAMP_UMN <= (RECT_SEL == RECT_ACDC_UMN);
      LAMP_FUNDAMENTAL_RECTIFIER <= (RECT_SEL == RECT_FUND);
      LAMP_LEVEL <= is_level(DISP_SEL);
      CONTENT_PERCENT_LAMP <= is_percent(DISP_SEL);
    end
  end

  // integration lamps; flashing uses the shared phase
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LAMP_INTEG_AUTO      <= 1'b0;
      LAMP_RUN             <= 1'b0;
      OUTSIDE_CONTROL_LAMP <= 1'b0;
    end else begin
      LAMP_INTEG_AUTO <= INTEG_AUTO_MODE;
      LAMP_RUN <= (INTEG_STATE == INTEG_RUN)
                  || ((INTEG_STATE == INTEG_STOP) && bl.phase);
      OUTSIDE_CONTROL_LAMP <= INTEG_EXTERNAL && (INTEG_STATE != INTEG_RESET);
    end
  end

  // hold lamps mirror the sequence state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LAMP_HOLD    <= 1'b0;
      LAMP_MAX     <= 1'b0;
      LAMP_MIN     <= 1'b0;
      HOLD_DISPLAY <= 1'b0;
    end else begin
      LAMP_HOLD    <= (hold_nxt == FPL_HOLD);
      LAMP_MAX     <= (hold_nxt == FPL_MAX);
      LAMP_MIN     <= (hold_nxt == FPL_MIN);
      HOLD_DISPLAY <= (hold_nxt != FPL_LIVE);
    end
  end

  // setting lamps: lit whenever a setting leaves its default; link lit as master, flashing on each rising sync edge as slave
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LAMP_TIMING_SOURCE             <= 1'b0;
      LAMP_DETECT_LIMIT              <= 1'b0;
      FILTER_SETTING_LAMP            <= 1'b0;
      AVERAGING_SETTING_LAMP         <= 1'b0;
      LAMP_VOLTAGE_TRANSFORMER_RATIO <= 1'b0;
      LAMP_CURRENT_TRANSFORMER_RATIO <= 1'b0;
      LAMP_SENSOR                    <= 1'b0;
      LAMP_RANGE_SKIP                <= 1'b0;
      ORDER_CAP_LAMP                 <= 1'b0;
      LAMP_LINK                      <= 1'b0;
      LAMP_RANGE_AUTO                <= 1'b0;
    end else begin
      LAMP_TIMING_SOURCE <= (SYNC_SRC != SYNC_SRC_U);
      LAMP_DETECT_LIMIT <= (SYNC_TIMEOUT != TOUT_100MS);
      FILTER_SETTING_LAMP <= (FILTER_SEL != FILT_500HZ);
      AVERAGING_SETTING_LAMP <= (AVG_COUNT != AVG_DEFAULT);
      LAMP_VOLTAGE_TRANSFORMER_RATIO <= (VOLTAGE_TRANSFORMER_RATIO != RATIO_ONE);
      LAMP_CURRENT_TRANSFORMER_RATIO <= (CURRENT_TRANSFORMER_RATIO != RATIO_ONE);
      LAMP_SENSOR <= (CURRENT_INPUT != CURIN_DIRECT);
      LAMP_RANGE_SKIP <= RANGE_SEL_OFF_U || RANGE_SEL_OFF_I
                         || (ZC_LEVEL_U != ZC_DEFAULT) || (ZC_LEVEL_I != ZC_DEFAULT);
      ORDER_CAP_LAMP <= (ORDER_LIMIT != ORDER_DEFAULT);
      LAMP_LINK <= (LINK_MODE == LINK_MASTER)
                   || ((LINK_MODE == LINK_SLAVE) && link_flash_r);
      LAMP_RANGE_AUTO <= RANGE_AUTO_U || RANGE_AUTO_I;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  property p_rect_combined;
    @(posedge CLK) disable iff (!RST_N)
      (RECT_SEL == RECT_ACDC_UMN) |=> (LAMP_DC && LAMP_AC && LAMP_UMN);
  endproperty
  a_rect_combined: assert property (p_rect_combined)
    else $error("umn rectifier lamps wrong");

  property p_rect_single;
    @(posedge CLK) disable iff (!RST_N)
      (RECT_SEL == RECT_FUND) |=> (!LAMP_DC && !LAMP_AC && LAMP_FUNDAMENTAL_RECTIFIER);
  endproperty
  a_rect_single: assert property (p_rect_single)
    else $error("fundamental lamp wrong");

  property p_level;
    @(posedge CLK) disable iff (!RST_N)
      is_level(DISP_SEL) |=> (LAMP_LEVEL && !CONTENT_PERCENT_LAMP);
  endproperty
  a_level: assert property (p_level)
    else $error("level lamp wrong");

  property p_run_flash;
    @(posedge CLK) disable iff (!RST_N)
      (INTEG_STATE == INTEG_STOP) && $past(INTEG_STATE == INTEG_STOP)
      |=> (LAMP_RUN == $past(bl.phase));
  endproperty
  a_run_flash: assert property (p_run_flash)
    else $error("run lamp not following blink");

  property p_ext_reset;
    @(posedge CLK) disable iff (!RST_N)
      (INTEG_STATE == INTEG_RESET) |=> (!LAMP_RUN && !OUTSIDE_CONTROL_LAMP);
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("integration lamps lit after reset");

  property p_hold_enter;
    @(posedge CLK) disable iff (!RST_N)
      (hold_r == FPL_LIVE) && shift_r && KEY_HOLD |=> LAMP_HOLD && (hold_r == FPL_HOLD);
  endproperty
  a_hold_enter: assert property (p_hold_enter)
    else $error("display hold not entered");

  property p_max_to_min;
    @(posedge CLK) disable iff (!RST_N)
      (hold_r == FPL_MAX) && KEY_HOLD |=> LAMP_MIN && !LAMP_MAX;
  endproperty
  a_max_to_min: assert property (p_max_to_min)
    else $error("max hold did not go to min");

  property p_min_exit;
    @(posedge CLK) disable iff (!RST_N)
      (hold_r == FPL_MIN) && KEY_HOLD |=> !HOLD_DISPLAY && !LAMP_MIN;
  endproperty
  a_min_exit: assert property (p_min_exit)
    else $error("min hold not cancelled");

  property p_order_cap;
    @(posedge CLK) disable iff (!RST_N)
      (ORDER_LIMIT == ORDER_DEFAULT) |=> !ORDER_CAP_LAMP;
  endproperty
  a_order_cap: assert property (p_order_cap)
    else $error("order cap lamp lit at default");

  property p_link_master;
    @(posedge CLK) disable iff (!RST_N)
      (LINK_MODE == LINK_MASTER) |=> LAMP_LINK;
  endproperty
  a_link_master: assert property (p_link_master)
    else $error("link lamp dark as master");

  c_hold_cycle: cover property (@(posedge CLK) disable iff (!RST_N)
    (hold_r == FPL_HOLD) ##[1:100] (hold_r == FPL_LIVE));
  c_max_min: cover property (@(posedge CLK) disable iff (!RST_N)
    (hold_r == FPL_MAX) ##[1:100] (hold_r == FPL_MIN));
  c_run_flash: cover property (@(posedge CLK) disable iff (!RST_N)
    (INTEG_STATE == INTEG_STOP) && $rose(LAMP_RUN));
endmodule : fpl_lamps

/* tb/fpl_keypad_model.sv */
// key scanner stand-in: issues one-cycle key strobes when asked
// assumes the caller runs 1 ns after a rising edge of clk
`timescale 1ns/1ns
module fpl_keypad_model (
  input  wire logic clk,
  output logic      key_shift,
  output logic      key_hold,
  output logic      key_maxmin
);
  // ****************************************************
  // key strobes
  // ****************************************************
  // keys idle from time zero so the lamps see no stray press
  initial begin
    key_shift  = 1'b0;
    key_hold   = 1'b0;
    key_maxmin = 1'b0;
  end
  // one press: 0 shift, 1 hold, 2 max/min; the strobe stands for exactly one cycle
  // shift before hold
  task automatic press(input int k);
    @(posedge clk);
    #1;
    key_shift  = (k == 0);
    key_hold   = (k == 1);
    key_maxmin = (k == 2);
    @(posedge clk);
    #1;
    {key_shift, key_hold, key_maxmin} = 3'h0;
  endtask : press
endmodule : fpl_keypad_model

/* tb/tb.sv */
// self-checking bench for the front panel lamp logic
// assumes a short blink half period of 4 cycles for simulation
`timescale 1ns/1ns
module tb
  import fpl_pkg::*;
;
  // ****************************************************
  // stimulus signals
  // ****************************************************
  logic CLK, RST_N, INTEG_AUTO_MODE, INTEG_EXTERNAL, RANGE_SEL_OFF_U, RANGE_SEL_OFF_I;
  logic LINK_SYNC_IN, RANGE_AUTO_U, RANGE_AUTO_I, KEY_SHIFT, KEY_HOLD, KEY_MAXMIN;
  logic [2:0]  RECT_SEL;
  logic [4:0]  DISP_SEL;
  logic [1:0]  INTEG_STATE, SYNC_SRC, SYNC_TIMEOUT, FILTER_SEL, CURRENT_INPUT, LINK_MODE;
  logic [7:0]  AVG_COUNT, ZC_LEVEL_U, ZC_LEVEL_I;
  logic [15:0] VOLTAGE_TRANSFORMER_RATIO, CURRENT_TRANSFORMER_RATIO;
  logic [5:0]  ORDER_LIMIT;
  logic LAMP_DC, LAMP_AC, LAMP_UMN, LAMP_FUNDAMENTAL_RECTIFIER, LAMP_LEVEL;
  logic CONTENT_PERCENT_LAMP, LAMP_INTEG_AUTO, LAMP_RUN, OUTSIDE_CONTROL_LAMP, LAMP_HOLD;
  logic LAMP_MAX, LAMP_MIN, HOLD_DISPLAY, LAMP_TIMING_SOURCE, LAMP_DETECT_LIMIT;
  logic FILTER_SETTING_LAMP, AVERAGING_SETTING_LAMP, LAMP_VOLTAGE_TRANSFORMER_RATIO;
  logic LAMP_CURRENT_TRANSFORMER_RATIO, LAMP_SENSOR, LAMP_RANGE_SKIP, ORDER_CAP_LAMP;
  logic LAMP_LINK, LAMP_RANGE_AUTO;
  logic [23:0] notes[$];
  logic [31:0] seed = 32'h0000001B;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          hs = 0;
  event        got;
  int          keys[8] = '{1, 0, 1, 2, 1, 2, 1, 1};
  int          hsq[8]  = '{0, 0, 1, 1, 0, 2, 3, 0};

  fpl_lamps #(
    .BLINK_HALF (4)
  ) u_fpl_lamps (
    .CLK, .RST_N, .RECT_SEL, .DISP_SEL, .INTEG_AUTO_MODE, .INTEG_STATE, .INTEG_EXTERNAL,
    .KEY_SHIFT, .KEY_HOLD, .KEY_MAXMIN, .SYNC_SRC, .SYNC_TIMEOUT, .FILTER_SEL, .AVG_COUNT,
    .VOLTAGE_TRANSFORMER_RATIO, .CURRENT_TRANSFORMER_RATIO, .CURRENT_INPUT,
    .RANGE_SEL_OFF_U, .RANGE_SEL_OFF_I, .ZC_LEVEL_U, .ZC_LEVEL_I, .ORDER_LIMIT,
    .LINK_MODE, .LINK_SYNC_IN, .RANGE_AUTO_U, .RANGE_AUTO_I,
    .LAMP_DC, .LAMP_AC, .LAMP_UMN, .LAMP_FUNDAMENTAL_RECTIFIER, .LAMP_LEVEL,
    .CONTENT_PERCENT_LAMP, .LAMP_INTEG_AUTO, .LAMP_RUN, .OUTSIDE_CONTROL_LAMP, .LAMP_HOLD,
    .LAMP_MAX, .LAMP_MIN, .HOLD_DISPLAY, .LAMP_TIMING_SOURCE, .LAMP_DETECT_LIMIT,
    .FILTER_SETTING_LAMP, .AVERAGING_SETTING_LAMP, .LAMP_VOLTAGE_TRANSFORMER_RATIO,
    .LAMP_CURRENT_TRANSFORMER_RATIO, .LAMP_SENSOR, .LAMP_RANGE_SKIP, .ORDER_CAP_LAMP,
    .LAMP_LINK, .LAMP_RANGE_AUTO
  );
  fpl_keypad_model u_fpl_keypad_model (
    .clk        (CLK),
    .key_shift  (KEY_SHIFT),
    .key_hold   (KEY_HOLD),
    .key_maxmin (KEY_MAXMIN)
  );

  // ****************************************************
  // helpers
  // ****************************************************
  // 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // expected lamp vector from the present inputs and the tracked hold mode
  function automatic logic [23:0] expv();
    logic [3:0] r;
    case (RECT_SEL)
      RECT_ACDC:     r = 4'hC;
      RECT_ACDC_UMN: r = 4'hE;
      RECT_DC:       r = 4'h8;
      RECT_AC:       r = 4'h4;
      default:       r = 4'h1;
    endcase
    return {r, DISP_SEL >= DISP_UK && DISP_SEL <= DISP_PK,
            DISP_SEL >= DISP_UHDK && DISP_SEL <= DISP_PHDK, INTEG_AUTO_MODE,
            INTEG_STATE == INTEG_RUN, INTEG_EXTERNAL && INTEG_STATE != INTEG_RESET,
            hs == 1, hs == 2, hs == 3, hs != 0, SYNC_SRC != SYNC_SRC_U,
            SYNC_TIMEOUT != TOUT_100MS, FILTER_SEL != FILT_500HZ, AVG_COUNT != AVG_DEFAULT,
            VOLTAGE_TRANSFORMER_RATIO != RATIO_ONE, CURRENT_TRANSFORMER_RATIO != RATIO_ONE,
            CURRENT_INPUT != CURIN_DIRECT, RANGE_SEL_OFF_U | RANGE_SEL_OFF_I |
            (ZC_LEVEL_U != ZC_DEFAULT) | (ZC_LEVEL_I != ZC_DEFAULT),
            ORDER_LIMIT != ORDER_DEFAULT, LINK_MODE == LINK_MASTER, RANGE_AUTO_U | RANGE_AUTO_I};
  endfunction : expv
  task automatic cmp_vec(input string name, input logic [23:0] e, input logic [23:0] a);
    samples_checked++;
    if (a !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, e, a);
    end
  endtask : cmp_vec
  task automatic cmp_cnt(input string name, input int lo, input int hi, input int a);
    samples_checked++;
    if (a < lo || a > hi) begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, a);
    end
  endtask : cmp_cnt
  // note the expectation, then tell the watcher a result stands
  task automatic note();
    notes.push_back(expv());
    -> got;
  endtask : note
  task automatic step();
    @(posedge CLK);
    #1;
    note();
  endtask : step
  // count cycles with a lamp high over n cycles; sel 0 run, 1 outside, 2 link
  task automatic count(input int sel, input int n, output int c);
    logic v;
    c = 0;
    repeat (n) begin
      @(posedge CLK);
      #1;
      v = sel == 0 ? LAMP_RUN : sel == 1 ? OUTSIDE_CONTROL_LAMP : LAMP_LINK;
      // an unknown lamp counts far out of range so no window can accept it
      c += $isunknown(v) ? 100 : int'(v);
    end
  endtask : count
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ****************************************************
  // watcher and watchdog
  // ****************************************************
  // oldest note against the lamps as they stand now
  initial forever begin
    logic [23:0] e;
    logic [23:0] a;
    @(got);
    e = notes.pop_front();
    a = {LAMP_DC, LAMP_AC, LAMP_UMN, LAMP_FUNDAMENTAL_RECTIFIER,
      LAMP_LEVEL, CONTENT_PERCENT_LAMP, LAMP_INTEG_AUTO, LAMP_RUN, OUTSIDE_CONTROL_LAMP,
      LAMP_HOLD, LAMP_MAX, LAMP_MIN, HOLD_DISPLAY, LAMP_TIMING_SOURCE, LAMP_DETECT_LIMIT,
      FILTER_SETTING_LAMP, AVERAGING_SETTING_LAMP, LAMP_VOLTAGE_TRANSFORMER_RATIO,
      LAMP_CURRENT_TRANSFORMER_RATIO, LAMP_SENSOR, LAMP_RANGE_SKIP, ORDER_CAP_LAMP,
      LAMP_LINK, LAMP_RANGE_AUTO};
    // one compare per lamp group so each carries its own name
    cmp_vec("rectifier lamps", 24'(e[23:20]), 24'(a[23:20]));
    cmp_vec("harmonic lamps", 24'(e[19:18]), 24'(a[19:18]));
    cmp_vec("integration lamps", 24'(e[17:15]), 24'(a[17:15]));
    cmp_vec("hold lamps", 24'(e[14:11]), 24'(a[14:11]));
    cmp_vec("sync and scale lamps", 24'(e[10:5]), 24'(a[10:5]));
    cmp_vec("input and link lamps", 24'(e[4:0]), 24'(a[4:0]));
  end
  // whole run is about 150 cycles; far past that means a hang
  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    logic [31:0] r, q;
    int          c;
    RST_N = 1'b0;
    {RECT_SEL, DISP_SEL, INTEG_AUTO_MODE, INTEG_STATE, INTEG_EXTERNAL, SYNC_SRC} = '0;
    {SYNC_TIMEOUT, CURRENT_INPUT, RANGE_SEL_OFF_U, RANGE_SEL_OFF_I, LINK_MODE} = '0;
    {LINK_SYNC_IN, RANGE_AUTO_U, RANGE_AUTO_I} = '0;
    FILTER_SEL = FILT_500HZ;
    AVG_COUNT = AVG_DEFAULT;
    VOLTAGE_TRANSFORMER_RATIO = RATIO_ONE;
    CURRENT_TRANSFORMER_RATIO = RATIO_ONE;
    ZC_LEVEL_U = ZC_DEFAULT;
    ZC_LEVEL_I = ZC_DEFAULT;
    ORDER_LIMIT = ORDER_DEFAULT;
    repeat (10) @(posedge CLK);
    #1;
    notes.push_back(24'h0);
    -> got;
    RST_N = 1'b1;
    @(posedge CLK);
    #1;
    // random settings, the averaging, ratio, zero-cross and order fields leaning to their default half the time
    repeat (60) begin
      r = xs();
      q = xs();
      RECT_SEL = 3'(r[7:0] % 5);
      DISP_SEL = q[5:1];
      INTEG_AUTO_MODE = r[15];
      INTEG_EXTERNAL = r[24];
      INTEG_STATE = r[14] ? INTEG_RUN : INTEG_RESET;
      SYNC_SRC = 2'(q[15:8] % 3);
      SYNC_TIMEOUT = 2'(q[23:16] % 3);
      FILTER_SEL = q[25:24];
      CURRENT_INPUT = 2'(q[31:26] % 3);
      AVG_COUNT = r[8] ? AVG_DEFAULT : q[15:8];
      VOLTAGE_TRANSFORMER_RATIO = r[9] ? RATIO_ONE : r[31:16];
      CURRENT_TRANSFORMER_RATIO = r[10] ? RATIO_ONE : q[31:16];
      ZC_LEVEL_U = r[11] ? ZC_DEFAULT : r[23:16];
      ZC_LEVEL_I = r[12] ? ZC_DEFAULT : q[23:16];
      ORDER_LIMIT = r[13] ? ORDER_DEFAULT : 6'(r[21:16] % 49 + 2);
      {RANGE_SEL_OFF_U, RANGE_SEL_OFF_I, RANGE_AUTO_U, RANGE_AUTO_I} = r[29:26];
      LINK_MODE = q[0] ? LINK_MASTER : LINK_OFF;
      step();
    end
    // hold, max and min walk including refused presses
    for (int i = 0; i < 8; i++) begin
      u_fpl_keypad_model.press(keys[i]);
      hs = hsq[i];
      note();
    end
    // stopped under outside control: run flashes half the time, outside lamp steady
    INTEG_EXTERNAL = 1'b1;
    INTEG_STATE = INTEG_STOP;
    repeat (2) @(posedge CLK);
    count(0, 16, c);
    cmp_cnt("run flash", 8, 8, c); // flashing run
    count(1, 16, c);
    cmp_cnt("outside lamp", 16, 16, c); // outside lamp steady
    INTEG_STATE = INTEG_RESET;
    step();
    // slave link: dark without sync, one short flash per sync edge
    LINK_MODE = LINK_SLAVE;
    count(2, 12, c);
    cmp_cnt("link idle", 0, 0, c); // no sync no flash
    LINK_SYNC_IN = 1'b1;
    count(2, 12, c);
    cmp_cnt("link flash", 1, 5, c); // flash per sync
    LINK_SYNC_IN = 1'b0;
    LINK_MODE = LINK_OFF;
    repeat (6) @(posedge CLK);
    #1;
    note();
    // let the watcher take the last note before the run ends
    @(posedge CLK);
    summarize();
  end
endmodule : tb
